// >>> rtl/psf_pkg.sv
// package: constants for the program status flags block
package psf_pkg;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'h00_D0;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00_00;
    localparam int CARRY_POS = 7;
    localparam int HALF_CARRY_POS = 6;
    localparam int USER_ZERO_POS = 5;
    localparam int BANK_HI_POS = 4;
    localparam int BANK_LO_POS = 3;
    localparam int EXCESS_POS = 2;
    localparam int USER_ONE_POS = 1;
    localparam int PARITY_POS = 0;
    localparam logic [7:0] PRODUCT_LIMIT = 8'h00_FF;
    localparam int BANK_SHIFT = 3;
    // arithmetic operation codes presented by the execution datapath
    typedef enum logic [2:0] {
        PSF_OP_NONE,
        PSF_OP_SUM,
        PSF_OP_SUM_CARRY_IN,
        PSF_OP_SUBTRACT_WITH_BORROW,
        PSF_OP_PRODUCT,
        PSF_OP_DIVIDE,
        PSF_OP_OTHER_ARITH
    } psf_op_t;
endpackage

// >>> rtl/psf_status_word.sv
// module: program status word with flag update, bit access and bank select
`timescale 1ns/100ps
`default_nettype none
module psf_status_word (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // special function register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_write,
    input wire logic i_sfr_read,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_bit_write,
    input wire logic [2:0] i_bit_index,
    input wire logic i_bit_value,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // execution datapath
    input wire logic i_op_valid,
    input wire logic [2:0] i_op_code,
    input wire logic [7:0] i_op_a,
    input wire logic [7:0] i_op_b,
    input wire logic [7:0] i_accumulator,
    // status outputs
    output logic [7:0] o_status_word,
    output logic o_carry_flag,
    output logic [4:0] o_bank_base
);
    logic [7:0] status_word_reg;
    logic [7:0] status_word_next;
    logic [7:0] rdata_reg;
    logic hit_reg;
    logic [4:0] bank_base_reg;
    logic carry_flag;
    logic half_carry_flag;
    logic user_flag_zero;
    logic user_flag_one;
    logic [1:0] bank_select;
    logic signed_excess_flag;
    logic parity_now;
    logic addr_hit;
    psf_pkg::psf_op_t op;
    logic cin;
    logic [8:0] full_sum;
    logic [4:0] nib_sum;
    logic [8:0] full_diff;
    logic [4:0] nib_diff;
    logic [15:0] product;
    logic sum_ovf;
    logic sub_ovf;
    logic [7:0] sw_word;
    logic sw_byte_hit;
    logic sw_bit_hit;
    logic op_sum;
    logic op_sum_cin;
    logic op_sub;
    logic op_prod;
    logic op_div;
    logic op_other;
    logic op_hits_carry;
    logic op_hits_excess;
    logic carry_next;
    logic half_carry_next;
    logic excess_next;
    logic product_big;
    logic divisor_zero;
    logic parity_chain;
    logic [7:0] rdata_next;
    logic hit_next;
    logic [4:0] bank_base_next;

    // layout checks: the flag logic assumes an eight-bit word with one bit per flag
    if (psf_pkg::CARRY_POS != 7 || psf_pkg::PARITY_POS != 0) begin : g_ends_bad
        $error("carry must sit at bit 7 and parity at bit 0");
    end
    if (psf_pkg::BANK_HI_POS != psf_pkg::BANK_LO_POS + 1) begin : g_bank_bad
        $error("bank select must be two adjacent bits");
    end
    if (psf_pkg::HALF_CARRY_POS == psf_pkg::USER_ZERO_POS || psf_pkg::EXCESS_POS == psf_pkg::USER_ONE_POS) begin : g_overlap_bad
        $error("arithmetic flags overlap the user flags");
    end
    // the five-bit base port only serves banks of eight bytes
    if (psf_pkg::BANK_SHIFT != 3) begin : g_shift_bad
        $error("bank step must be eight bytes");
    end
    if (psf_pkg::PRODUCT_LIMIT != 8'hFF) begin : g_limit_bad
        $error("product limit must be the largest eight-bit value");
    end

    assign op = psf_pkg::psf_op_t'(i_op_code);
    assign addr_hit = (i_sfr_addr == psf_pkg::STATUS_WORD_ADDR);
    // accumulator parity as an explicit xor chain, one stage per bit
    always_comb begin
        parity_chain = 1'b0;
        for (int i = 0; i < 8; i++) begin
            parity_chain = parity_chain ^ i_accumulator[i];
        end
    end
    assign parity_now = parity_chain;
    assign carry_flag = status_word_reg[psf_pkg::CARRY_POS];
    assign half_carry_flag = status_word_reg[psf_pkg::HALF_CARRY_POS];
    assign user_flag_zero = status_word_reg[psf_pkg::USER_ZERO_POS];
    assign user_flag_one = status_word_reg[psf_pkg::USER_ONE_POS];
    assign bank_select = status_word_reg[psf_pkg::BANK_HI_POS:psf_pkg::BANK_LO_POS];
    assign signed_excess_flag = status_word_reg[psf_pkg::EXCESS_POS];

    // operand arithmetic seen by the flag logic
    always_comb begin
        cin = (op == psf_pkg::PSF_OP_SUM) ? 1'b0 : carry_flag;
        full_sum = {1'b0, i_op_a} + {1'b0, i_op_b} + {8'h00, cin};
        nib_sum = {1'b0, i_op_a[3:0]} + {1'b0, i_op_b[3:0]} + {4'h0, cin};
        full_diff = {1'b0, i_op_a} - {1'b0, i_op_b} - {8'h00, carry_flag};
        nib_diff = {1'b0, i_op_a[3:0]} - {1'b0, i_op_b[3:0]} - {4'h0, carry_flag};
        product = i_op_a * i_op_b;
        sum_ovf = (i_op_a[7] == i_op_b[7]) && (full_sum[7] != i_op_a[7]);
        sub_ovf = (i_op_a[7] != i_op_b[7]) && (full_diff[7] != i_op_a[7]);
    end

    // one-hot decode of the operation code, qualified by the valid pulse
    always_comb begin
        op_sum = 1'b0;
        op_sum_cin = 1'b0;
        op_sub = 1'b0;
        op_prod = 1'b0;
        op_div = 1'b0;
        op_other = 1'b0;
        if (i_op_valid) begin
            case (op)
                psf_pkg::PSF_OP_SUM: begin
                    op_sum = 1'b1;
                end
                psf_pkg::PSF_OP_SUM_CARRY_IN: begin
                    op_sum_cin = 1'b1;
                end
                psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW: begin
                    op_sub = 1'b1;
                end
                psf_pkg::PSF_OP_PRODUCT: begin
                    op_prod = 1'b1;
                end
                psf_pkg::PSF_OP_DIVIDE: begin
                    op_div = 1'b1;
                end
                psf_pkg::PSF_OP_OTHER_ARITH: begin
                    op_other = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // an unknown or idle code leaves every arithmetic flag alone
        op_hits_carry = op_sum || op_sum_cin || op_sub || op_prod || op_div || op_other;
        op_hits_excess = op_sum || op_sum_cin || op_sub || op_prod || op_div;
    end

    assign product_big = (product > {8'h00, psf_pkg::PRODUCT_LIMIT});
    assign divisor_zero = (i_op_b == 8'h00);

    // software view: a byte write wins over a bit write in the same cycle
    assign sw_byte_hit = i_sfr_write && addr_hit;
    assign sw_bit_hit = i_bit_write && addr_hit && !sw_byte_hit;
    always_comb begin
        sw_word = status_word_reg;
        if (sw_byte_hit) begin
            sw_word = i_sfr_wdata;
        end else if (sw_bit_hit) begin
            sw_word[i_bit_index] = i_bit_value;
        end
    end

    // carry: out of bit 7 on sums, borrow on subtract, cleared by other arithmetic
    always_comb begin
        carry_next = 1'b0;
        if (op_sum || op_sum_cin) begin
            carry_next = full_sum[8];
        end else if (op_sub) begin
            carry_next = full_diff[8];
        end
    end

    // half-carry: carry into or borrow from the upper nibble
    always_comb begin
        half_carry_next = 1'b0;
        if (op_sum || op_sum_cin) begin
            half_carry_next = nib_sum[4];
        end else if (op_sub) begin
            half_carry_next = nib_diff[4];
        end
    end

    // overflow: one cause per op class, left unchanged by other arithmetic
    always_comb begin
        excess_next = 1'b0;
        if (op_sum || op_sum_cin) begin
            excess_next = sum_ovf;
        end else if (op_sub) begin
            excess_next = sub_ovf;
        end else if (op_prod) begin
            excess_next = product_big;
        end else if (op_div) begin
            excess_next = divisor_zero;
        end
    end

    // next word: arithmetic flags override a same-cycle write, user bits and bank follow software
    always_comb begin
        status_word_next = sw_word;
        if (op_hits_carry) begin
            status_word_next[psf_pkg::CARRY_POS] = carry_next;
            status_word_next[psf_pkg::HALF_CARRY_POS] = half_carry_next;
        end
        if (op_hits_excess) begin
            status_word_next[psf_pkg::EXCESS_POS] = excess_next;
        end
        // hardware never touches the user flags
        status_word_next[psf_pkg::USER_ZERO_POS] = sw_word[psf_pkg::USER_ZERO_POS];
        status_word_next[psf_pkg::USER_ONE_POS] = sw_word[psf_pkg::USER_ONE_POS];
        // parity is recomputed every cycle, so a write to bit 0 is lost
        status_word_next[psf_pkg::PARITY_POS] = parity_now;
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            status_word_reg <= psf_pkg::STATUS_WORD_RESET;
        end else begin
            status_word_reg <= status_word_next;
        end
    end

    // read data carries live parity so a read just after an accumulator change is current
    always_comb begin
        hit_next = i_sfr_read && addr_hit;
        rdata_next = 8'h00;
        if (hit_next) begin
            rdata_next = {status_word_reg[7:1], parity_now};
        end
    end

    // register read path
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= 8'h00;
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= hit_next;
            rdata_reg <= rdata_next;
        end
    end

    // working register bank base address
    always_comb begin
        case (status_word_next[psf_pkg::BANK_HI_POS:psf_pkg::BANK_LO_POS])
            2'b00: begin
                bank_base_next = 5'h00;
            end
            2'b01: begin
                bank_base_next = 5'h08;
            end
            2'b10: begin
                bank_base_next = 5'h10;
            end
            2'b11: begin
                bank_base_next = 5'h18;
            end
            default: begin
                bank_base_next = 5'h00;
            end
        endcase
    end

    // base moves on the same edge as the word so register accesses never see a stale bank
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            bank_base_reg <= 5'h00;
        end else begin
            bank_base_reg <= bank_base_next;
        end
    end

    assign o_sfr_rdata = rdata_reg;
    assign o_sfr_hit = hit_reg;
    assign o_status_word = status_word_reg;
    assign o_carry_flag = carry_flag;
    assign o_bank_base = bank_base_reg;
endmodule
`default_nettype wire

// >>> tb/psf_exec_model.sv
// partner: execution datapath presenting one-cycle flag update requests
`timescale 1ns/100ps
`default_nettype none
module psf_exec_model (
    // request from the bench
    input wire logic i_clock, i_go,
    input wire logic [2:0] i_code,
    input wire logic [7:0] i_a, i_b,
    // operation pins toward the status word
    output logic o_op_valid,
    output logic [2:0] o_op_code,
    output logic [7:0] o_op_a, o_op_b
);
    // operands are scrambled between requests so stale values are never trusted
    always_ff @(posedge i_clock) begin
        o_op_valid <= i_go;
        o_op_code <= i_go ? i_code : ~i_code;
        o_op_a <= i_go ? i_a : ~i_a;
        o_op_b <= i_go ? i_b : ~i_b;
    end
endmodule
`default_nettype wire

// >>> tb/psf_status_word_properties.sv
// checker: flag, parity and read timing properties of the status word
`timescale 1ns/100ps
`default_nettype none
module psf_status_word_properties (
    input wire logic i_clock, i_rstn, i_sfr_read, i_sfr_write, i_bit_write, i_op_valid, o_sfr_hit, o_carry_flag,
    input wire logic [7:0] i_sfr_addr, i_op_a, i_op_b, i_accumulator, o_status_word,
    input wire logic [2:0] i_op_code
);
    wire logic [8:0] sum = i_op_a + i_op_b;
    wire logic [4:0] nib = i_op_a[3:0] + i_op_b[3:0];
    wire logic [15:0] prod = i_op_a * i_op_b;
    wire logic sum_carry = sum[8];
    wire logic nib_carry = nib[4];
    wire logic sum_ovf = (i_op_a[7] == i_op_b[7]) && (sum[7] != i_op_a[7]);
    wire logic prod_big = prod > 16'h00FF;
    wire logic div_zero = i_op_b == 8'h00;
    wire logic is_op = i_op_valid && !i_sfr_write && !i_bit_write;
    wire logic is_sum = is_op && i_op_code == psf_pkg::PSF_OP_SUM;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    sequence s_read_hit; i_sfr_read && i_sfr_addr == psf_pkg::STATUS_WORD_ADDR; endsequence
    property p_carry; is_sum |=> o_carry_flag == $past(sum_carry); endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong after sum");
    property p_half; is_sum |=> o_status_word[6] == $past(nib_carry); endproperty
    a_half: assert property (p_half) else $error("half carry wrong after sum");
    property p_sum_ovf; is_sum |=> o_status_word[2] == $past(sum_ovf); endproperty
    a_sum_ovf: assert property (p_sum_ovf) else $error("overflow wrong after sum");
    property p_prod; is_op && i_op_code == psf_pkg::PSF_OP_PRODUCT |=> o_status_word[2] == $past(prod_big); endproperty
    a_prod: assert property (p_prod) else $error("overflow wrong after product");
    property p_div; is_op && i_op_code == psf_pkg::PSF_OP_DIVIDE |=> o_status_word[2] == $past(div_zero); endproperty
    a_div: assert property (p_div) else $error("overflow wrong after divide");
    property p_user; is_op |=> $stable(o_status_word[5]) && $stable(o_status_word[1]); endproperty
    a_user: assert property (p_user) else $error("user flag changed by hardware");
    property p_parity; $past(i_rstn) |-> o_status_word[0] == ^$past(i_accumulator); endproperty
    a_parity: assert property (p_parity) else $error("parity bit does not follow accumulator");
    property p_hit; s_read_hit |=> o_sfr_hit; endproperty
    a_hit: assert property (p_hit) else $error("read at status address not answered");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// testbench: status word access, flag update and bank select checks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clock = 0, i_rstn = 0, i_sfr_write = 0, i_sfr_read = 0, i_bit_write = 0, i_bit_value = 0, go = 0;
    logic [7:0] i_sfr_addr = 8'hD0, i_sfr_wdata = 8'h00, i_accumulator = 8'h00, a = 8'h00, b = 8'h00;
    logic [2:0] i_bit_index = 3'h0, code = 3'h0, i_op_code;
    logic [7:0] i_op_a, i_op_b, o_sfr_rdata, o_status_word;
    logic i_op_valid, o_sfr_hit, o_carry_flag;
    logic [4:0] o_bank_base;
    logic [31:0] ops [10] = '{32'h0180_8084, 32'h0600_0004, 32'h0108_0840, 32'h017F_0144, 32'h0300_01C0,
        32'h0200_0000, 32'h0410_1004, 32'h040F_1100, 32'h0510_0004, 32'h0510_0100};
    int err_count = 0, num_checks = 0;
    always #20 i_clock = ~i_clock;
    psf_exec_model i_psf_exec_model (.i_clock(i_clock), .i_go(go), .i_code(code), .i_a(a), .i_b(b),
        .o_op_valid(i_op_valid), .o_op_code(i_op_code), .o_op_a(i_op_a), .o_op_b(i_op_b));
    psf_status_word i_psf_status_word (.i_clock(i_clock), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr),
        .i_sfr_write(i_sfr_write), .i_sfr_read(i_sfr_read), .i_sfr_wdata(i_sfr_wdata), .i_bit_write(i_bit_write),
        .i_bit_index(i_bit_index), .i_bit_value(i_bit_value), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
        .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_op_a(i_op_a), .i_op_b(i_op_b),
        .i_accumulator(i_accumulator), .o_status_word(o_status_word), .o_carry_flag(o_carry_flag),
        .o_bank_base(o_bank_base));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bit writes take the index from d[2:0] and the value from d[3]
    task automatic wr(input logic bit_op, input logic [7:0] d, input logic [7:0] acc);
        @(posedge i_clock);
        i_sfr_write <= !bit_op;
        i_bit_write <= bit_op;
        i_sfr_addr <= 8'hD0;
        i_sfr_wdata <= d;
        {i_bit_value, i_bit_index} <= d[3:0];
        i_accumulator <= acc;
        @(posedge i_clock);
        i_sfr_write <= 0;
        i_bit_write <= 0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge i_clock);
        i_sfr_read <= 1;
        i_sfr_addr <= ad;
        @(posedge i_clock);
        i_sfr_read <= 0;
        #1;
        chk(o_sfr_rdata, exp);
        chk({7'h00, o_sfr_hit}, {7'h00, ad == 8'hD0});
    endtask
    task automatic op(input logic [31:0] t);
        @(posedge i_clock);
        go <= 1;
        {code, a, b} <= t[26:8];
        @(posedge i_clock);
        go <= 0;
        @(posedge i_clock);
        #1;
        chk(o_status_word & 8'hC4, t[7:0]);
        chk({7'h00, o_carry_flag}, {7'h00, t[7]});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        i_rstn <= 1;
        rd(8'hD0, 8'h00);
        rd(8'hD1, 8'h00);
        wr(0, 8'hFE, 8'h01);
        rd(8'hD0, 8'hFF);
        wr(0, 8'h23, 8'h03);
        rd(8'hD0, 8'h22);
        $display("test reset, decode and byte access done");
        for (int i = 0; i < 10; i++) begin
            op(ops[i]);
        end
        rd(8'hD0, 8'h22);
        $display("test flag update done");
        for (int k = 0; k < 4; k++) begin
            wr(0, 8'(k << 3), 8'h03);
            chk({3'h0, o_bank_base}, 8'(k * 8));
        end
        wr(1, 8'h03, 8'h03);
        wr(1, 8'h09, 8'h03);
        wr(1, 8'h08, 8'h03);
        chk({3'h0, o_bank_base}, 8'h10);
        rd(8'hD0, 8'h12);
        $display("test bank select and bit access done");
        i_rstn <= 0;
        repeat (4) @(posedge i_clock);
        i_rstn <= 1;
        rd(8'hD0, 8'h00);
        chk({3'h0, o_bank_base}, 8'h00);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
bind psf_status_word psf_status_word_properties i_psf_status_word_properties (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_sfr_read(i_sfr_read), .i_sfr_write(i_sfr_write), .i_bit_write(i_bit_write), .i_op_valid(i_op_valid),
    .o_sfr_hit(o_sfr_hit), .o_carry_flag(o_carry_flag), .i_sfr_addr(i_sfr_addr), .i_op_a(i_op_a), .i_op_b(i_op_b),
    .i_accumulator(i_accumulator), .o_status_word(o_status_word), .i_op_code(i_op_code));
`default_nettype wire
